// >>> rtl/tsm_regs.svh
// register offsets, field positions and reset values of the slope monitor
// definitions only; included by the slope monitor design files
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TSM_OFS_GAIN    8'h3D
`define TSM_OFS_CFG     8'h3E
`define TSM_OFS_FLAGS   8'h3F
`define TSM_OFS_RESU1   8'h40
`define TSM_OFS_LIMU1   8'h41
`define TSM_OFS_LIML1   8'h42
`define TSM_OFS_SMP1    8'h43
`define TSM_OFS_RESU2   8'h44
`define TSM_OFS_RESL    8'h45
`define TSM_OFS_LIMU2   8'h46
`define TSM_OFS_LIML2   8'h47
`define TSM_OFS_SMP2    8'h48
`define TSM_OFS_PKI1    8'h49
`define TSM_OFS_PKF1    8'h4A
`define TSM_OFS_PKI2    8'h4B
`define TSM_OFS_PKF2    8'h4C

// ----------------------------------------
// fields
// ----------------------------------------
`define TSM_CFG_EN      5
`define TSM_CFG_MASK2   4
`define TSM_CFG_CHAN1_ALERT_BLOCK   3
`define TSM_CFG_WMASK   8'h3F
`define TSM_FL_TURN2    7
`define TSM_FL_TURN1    6
`define TSM_FL_PAR2     5
`define TSM_FL_PAR1     4
`define TSM_FL_HI2      3
`define TSM_FL_HI1      2
`define TSM_FL_LO2      1
`define TSM_FL_LO1      0
`define TSM_SMP_MAXK    4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define TSM_RST_BYTE    8'h00
`define TSM_RST_SMP     4'h0

`endif

// >>> rtl/tsm_pkg.sv
// types shared by the slope monitor modules
// temperatures are unsigned 8.3 fixed point, 0.125 degree steps
package tsm_pkg;
   typedef logic [10:0] tsm_temp_t;

   typedef enum logic [1:0]
   {
      TSM_IDLE = 2'b00,
      TSM_RUN  = 2'b01
   } tsm_st_t;

   typedef struct packed {
      tsm_st_t     st;
      tsm_temp_t   start;
      tsm_temp_t   ref_t;
      tsm_temp_t   peak;
      logic [8:0]  cnt;
      logic        dir_vld;
      logic        dir_dn;
      logic        turned;
      logic        parity;
      logic        done;
      logic        hi;
      logic        lo;
      logic [11:0] result;
      tsm_temp_t   peak_o;
   } tsm_chan_t;

   typedef struct packed {
      logic [7:0]  gain;
      logic [7:0]  cfg;
      logic [7:0]  flags;
      logic [7:0]  lim_u1;
      logic [3:0]  lim_l1;
      logic [3:0]  smp1;
      logic [7:0]  lim_u2;
      logic [3:0]  lim_l2;
      logic [3:0]  smp2;
      logic [11:0] res1;
      logic [11:0] res2;
      tsm_temp_t   peak1;
      tsm_temp_t   peak2;
      logic [7:0]  rdata;
      logic        alert;
   } tsm_top_t;
endpackage

// >>> rtl/tsm_chan.sv
// one slope engine: difference over a sample period, reversals, peak
// samples arrive as one-cycle strobes from conversion logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_chan
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              enable,
   input  wire logic [2:0]        gain,
   input  wire logic [3:0]        smp_code,
   input  wire logic [2:0]        hyst_code,
   input  wire logic [11:0]       limit,
   input  wire logic              tvalid,
   input  wire tsm_pkg::tsm_temp_t temp,
   output logic                   done,
   output logic [11:0]            result,
   output logic                   turned,
   output logic                   parity,
   output logic                   hi,
   output logic                   lo,
   output tsm_pkg::tsm_temp_t     peak
);
   import tsm_pkg::*;

   tsm_chan_t q_q, q_d;
   logic signed [11:0] delta;
   logic signed [11:0] diff;
   logic        [11:0] mag;
   logic        [3:0]  k;
   logic signed [19:0] scaled;
   logic signed [12:0] lim_s;
   logic signed [12:0] res_s;
   logic               dn;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [11:0] hyst_lsb(input logic [2:0] c);
      case (c)
         3'h0: hyst_lsb = 12'h000;
         3'h1: hyst_lsb = 12'h001;
         3'h2: hyst_lsb = 12'h002;
         3'h3: hyst_lsb = 12'h004;
         3'h4: hyst_lsb = 12'h008;
         3'h5: hyst_lsb = 12'h010;
         3'h6: hyst_lsb = 12'h018;
         default: hyst_lsb = 12'h020;
      endcase
   endfunction

   function automatic logic [11:0] sat12(input logic signed [19:0] v);
      if (v > 20'sh007FF)
         sat12 = 12'h7FF;
      else if (v < -20'sh00800)
         sat12 = 12'h800;
      else
         sat12 = v[11:0];
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      q_d = q_q;
      q_d.done = 1'b0;
      q_d.hi = 1'b0;
      q_d.lo = 1'b0;
      // flags of a published period must not leak into the next one
      if (q_q.done)
      begin
         q_d.turned = 1'b0;  // [RQ6]
         q_d.parity = 1'b0;  // [RQ7]
      end
      k = (smp_code > `TSM_SMP_MAXK) ? `TSM_SMP_MAXK : smp_code;  // [RQ14]
      delta = $signed({1'b0, temp}) - $signed({1'b0, q_q.ref_t});
      diff = $signed({1'b0, temp}) - $signed({1'b0, q_q.start});
      mag = delta[11] ? 12'(-delta) : delta;
      dn = delta[11];
      scaled = (20'(diff) <<< gain) >>> k;  // [RQ1] [RQ17]
      lim_s = $signed({1'b0, limit});
      res_s = 13'($signed(sat12(scaled)));
      case (q_q.st)
         TSM_IDLE:
            if (enable && tvalid)
            begin
               q_d.st = TSM_RUN;
               q_d.start = temp;
               q_d.ref_t = temp;
               q_d.peak = temp;
               q_d.cnt = 9'h000;
               q_d.dir_vld = 1'b0;
               q_d.turned = 1'b0;
               q_d.parity = 1'b0;
            end
         TSM_RUN:
            if (tvalid)
            begin
               if (temp > q_q.peak)
                  q_d.peak = temp;
               // reference moves only on a real move or at a period start, so dither never counts
               if (mag > hyst_lsb(hyst_code))  // [RQ5]
               begin
                  q_d.ref_t = temp;
                  q_d.dir_vld = 1'b1;
                  q_d.dir_dn = dn;
                  if (q_q.dir_vld && (q_q.dir_dn != dn))
                  begin
                     q_d.turned = 1'b1;
                     q_d.parity = ~q_q.parity;
                  end
               end
               q_d.cnt = q_q.cnt + 9'h001;
               if (q_d.cnt == (9'h001 << k))
               begin
                  q_d.done = 1'b1;  // [RQ17]
                  q_d.result = 12'(res_s);
                  q_d.hi = res_s > lim_s;  // [RQ8]
                  q_d.lo = res_s < -lim_s;  // [RQ9]
                  q_d.peak_o = q_d.peak;  // [RQ15]
                  // last sample opens the next period
                  q_d.start = temp;
                  q_d.ref_t = temp;
                  q_d.peak = temp;
                  q_d.cnt = 9'h000;
                  q_d.dir_vld = 1'b0;
               end
            end
         default:
            q_d.st = TSM_IDLE;
      endcase
      if (!enable)
      begin
         q_d.st = TSM_IDLE;  // [RQ2]
         q_d.done = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         q_q <= '0;
      else
         q_q <= q_d;
   end

   assign done = q_q.done;
   assign result = q_q.result;
   assign turned = q_q.turned;
   assign parity = q_q.parity;
   assign hi = q_q.hi;
   assign lo = q_q.lo;
   assign peak = q_q.peak_o;
endmodule
`default_nettype wire

// >>> rtl/tsm_slope_monitor.sv
// temperature slope monitor: register bank, two slope engines, alert pin
// register strobes come from a management-bus front end on sys_clk
//
// Operation
// RQ1: 3-bit gain code n multiplies the difference by 2 to the n.
// RQ2: slope calculation runs only while the enable bit is set; resets off.
// RQ3: channel-2 mask bit set keeps channel-2 events off the alert pin.
// RQ4: channel-1 mask bit set keeps channel-1 events off the alert pin.
// RQ5: reversal counts only when deviation exceeds the hysteresis setting.
// RQ6: read-only flags show that a channel's slope changed direction.
// RQ7: read-only flags show odd or even count of reversals.
// RQ8: high flag sets on result above limit; status read clears it.
// RQ9: low flag sets on negative result beyond limit; status read clears.
// RQ10: upper eight result bits readable per channel.
// RQ11: lower four result bits of both channels share one byte.
// RQ12: result over limit with mask clear asserts the alert pin.
// RQ13: lower four limit bits live in bits 7:4; reset to zero.
// RQ14: 4-bit code picks 2,3,5,9,17,33,65,129 or 257 samples.
// RQ15: integer part of the period peak temperature is readable.
// RQ16: fraction of the period peak reads in bits 7:5, eighth steps.
// RQ17: slope is difference over sample count times gain, once per period.
`timescale 1ns/1ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_slope_monitor
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic [7:0]              reg_rdata,
   input  wire logic               ch1_temp_valid,
   input  wire tsm_pkg::tsm_temp_t ch1_temp,
   input  wire logic               ch2_temp_valid,
   input  wire tsm_pkg::tsm_temp_t ch2_temp,
   output logic                    alert_n
);
   import tsm_pkg::*;

   tsm_top_t   q_q, q_d;
   logic       c1_done, c2_done;
   logic       c1_turn, c2_turn;
   logic       c1_par, c2_par;
   logic       c1_hi, c2_hi;
   logic       c1_lo, c2_lo;
   logic [11:0] c1_res, c2_res;
   tsm_temp_t  c1_peak, c2_peak;
   logic       flags_rd;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rd_mux(input tsm_top_t s, input logic [7:0] a);
      case (a)
         `TSM_OFS_GAIN:  rd_mux = s.gain;
         `TSM_OFS_CFG:   rd_mux = s.cfg;
         `TSM_OFS_FLAGS: rd_mux = s.flags;
         `TSM_OFS_RESU1: rd_mux = s.res1[11:4];  // [RQ10]
         `TSM_OFS_LIMU1: rd_mux = s.lim_u1;
         `TSM_OFS_LIML1: rd_mux = {s.lim_l1, 4'h0};
         `TSM_OFS_SMP1:  rd_mux = {4'h0, s.smp1};
         `TSM_OFS_RESU2: rd_mux = s.res2[11:4];  // [RQ10]
         `TSM_OFS_RESL:  rd_mux = {s.res2[3:0], s.res1[3:0]};  // [RQ11]
         `TSM_OFS_LIMU2: rd_mux = s.lim_u2;
         `TSM_OFS_LIML2: rd_mux = {s.lim_l2, 4'h0};
         `TSM_OFS_SMP2:  rd_mux = {4'h0, s.smp2};
         `TSM_OFS_PKI1:  rd_mux = s.peak1[10:3];  // [RQ15]
         `TSM_OFS_PKF1:  rd_mux = {s.peak1[2:0], 5'h00};  // [RQ16]
         `TSM_OFS_PKI2:  rd_mux = s.peak2[10:3];  // [RQ15]
         `TSM_OFS_PKF2:  rd_mux = {s.peak2[2:0], 5'h00};  // [RQ16]
         default:        rd_mux = 8'h00;
      endcase
   endfunction

   function automatic logic alert_of(input logic [7:0] cfg, input logic [7:0] fl);
      alert_of = (!cfg[`TSM_CFG_CHAN1_ALERT_BLOCK] && (fl[`TSM_FL_HI1] || fl[`TSM_FL_LO1]))
              || (!cfg[`TSM_CFG_MASK2] && (fl[`TSM_FL_HI2] || fl[`TSM_FL_LO2]));
   endfunction

   // ----------------------------------------
   // slope engines
   // ----------------------------------------
   tsm_chan u_ch1
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .enable    (q_q.cfg[`TSM_CFG_EN]),
      .gain      (q_q.gain[2:0]),
      .smp_code  (q_q.smp1),
      .hyst_code (q_q.cfg[2:0]),
      .limit     ({q_q.lim_u1, q_q.lim_l1}),
      .tvalid    (ch1_temp_valid),
      .temp      (ch1_temp),
      .done      (c1_done),
      .result    (c1_res),
      .turned    (c1_turn),
      .parity    (c1_par),
      .hi        (c1_hi),
      .lo        (c1_lo),
      .peak      (c1_peak)
   );

   tsm_chan u_ch2
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .enable    (q_q.cfg[`TSM_CFG_EN]),
      .gain      (q_q.gain[5:3]),
      .smp_code  (q_q.smp2),
      .hyst_code (q_q.cfg[2:0]),
      .limit     ({q_q.lim_u2, q_q.lim_l2}),
      .tvalid    (ch2_temp_valid),
      .temp      (ch2_temp),
      .done      (c2_done),
      .result    (c2_res),
      .turned    (c2_turn),
      .parity    (c2_par),
      .hi        (c2_hi),
      .lo        (c2_lo),
      .peak      (c2_peak)
   );

   // ----------------------------------------
   // register bank
   // ----------------------------------------
   assign flags_rd = reg_rd && (reg_addr == `TSM_OFS_FLAGS);

   always_comb
   begin
      q_d = q_q;
      if (reg_wr)
      begin
         case (reg_addr)
            `TSM_OFS_GAIN:  q_d.gain = reg_wdata;  // [RQ1]
            `TSM_OFS_CFG:   q_d.cfg = reg_wdata & `TSM_CFG_WMASK;  // [RQ2]
            `TSM_OFS_LIMU1: q_d.lim_u1 = reg_wdata;  // [RQ12]
            `TSM_OFS_LIML1: q_d.lim_l1 = reg_wdata[7:4];  // [RQ13]
            `TSM_OFS_SMP1:  q_d.smp1 = reg_wdata[3:0];  // [RQ14]
            `TSM_OFS_LIMU2: q_d.lim_u2 = reg_wdata;  // [RQ12]
            `TSM_OFS_LIML2: q_d.lim_l2 = reg_wdata[7:4];  // [RQ13]
            `TSM_OFS_SMP2:  q_d.smp2 = reg_wdata[3:0];  // [RQ14]
            default:        q_d.gain = q_q.gain;
         endcase
      end
      if (reg_rd)
         q_d.rdata = rd_mux(q_q, reg_addr);
      // clear first, then sets, so an event in the read cycle survives
      if (flags_rd)
         q_d.flags[3:0] = 4'h0;  // [RQ8] [RQ9]
      if (c1_done)
      begin
         q_d.res1 = c1_res;  // [RQ10] [RQ11]
         q_d.peak1 = c1_peak;  // [RQ15] [RQ16]
         q_d.flags[`TSM_FL_TURN1] = c1_turn;  // [RQ6]
         q_d.flags[`TSM_FL_PAR1] = c1_par;  // [RQ7]
         if (c1_hi)
            q_d.flags[`TSM_FL_HI1] = 1'b1;  // [RQ8]
         if (c1_lo)
            q_d.flags[`TSM_FL_LO1] = 1'b1;  // [RQ9]
      end
      if (c2_done)
      begin
         q_d.res2 = c2_res;  // [RQ10] [RQ11]
         q_d.peak2 = c2_peak;  // [RQ15] [RQ16]
         q_d.flags[`TSM_FL_TURN2] = c2_turn;  // [RQ6]
         q_d.flags[`TSM_FL_PAR2] = c2_par;  // [RQ7]
         if (c2_hi)
            q_d.flags[`TSM_FL_HI2] = 1'b1;  // [RQ8]
         if (c2_lo)
            q_d.flags[`TSM_FL_LO2] = 1'b1;  // [RQ9]
      end
      // alert follows the sticky flags, so a status read releases the pin
      q_d.alert = alert_of(q_d.cfg, q_d.flags);  // [RQ3] [RQ4] [RQ12]
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         q_q <= '0;
      else
         q_q <= q_d;
   end

   assign reg_rdata = q_q.rdata;
   assign alert_n = ~q_q.alert;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   gain_write_a: assert property (  // [RQ1]
      reg_wr && (reg_addr == `TSM_OFS_GAIN) |=> q_q.gain == $past(reg_wdata))
      else $error("gain register did not take the write");

   engine_gate_a: assert property (  // [RQ2]
      !q_q.cfg[`TSM_CFG_EN] |=> !c1_done && !c2_done)
      else $error("slope result produced while disabled");

   mask_two_a: assert property (  // [RQ3]
      (q_q.flags[`TSM_FL_HI2] || q_q.flags[`TSM_FL_LO2]) && !q_q.cfg[`TSM_CFG_MASK2] |-> !alert_n)
      else $error("unmasked channel 2 event left alert high");

   mask_one_a: assert property (  // [RQ4]
      (q_q.flags[`TSM_FL_HI1] || q_q.flags[`TSM_FL_LO1]) && !q_q.cfg[`TSM_CFG_CHAN1_ALERT_BLOCK] |-> !alert_n)
      else $error("unmasked channel 1 event left alert high");

   both_masked_a: assert property (  // [RQ12]
      q_q.cfg[`TSM_CFG_CHAN1_ALERT_BLOCK] && q_q.cfg[`TSM_CFG_MASK2] |-> alert_n)
      else $error("alert asserted with both channels masked");

   turn_flag_a: assert property (  // [RQ6]
      c1_done |=> q_q.flags[`TSM_FL_TURN1] == $past(c1_turn))
      else $error("channel 1 turn flag not published");

   parity_flag_a: assert property (  // [RQ7]
      c2_done |=> q_q.flags[`TSM_FL_PAR2] == $past(c2_par))
      else $error("channel 2 parity flag not published");

   high_sticky_a: assert property (  // [RQ8]
      c1_done && c1_hi |=> q_q.flags[`TSM_FL_HI1] ##1 (q_q.flags[`TSM_FL_HI1] || $past(flags_rd)))
      else $error("channel 1 high flag lost without a status read");

   read_clear_a: assert property (  // [RQ9]
      flags_rd && !c1_done && !c2_done |=> q_q.flags[3:0] == 4'h0)
      else $error("status read did not clear the limit flags");

   result_pub_a: assert property (  // [RQ10]
      reg_rd && (reg_addr == `TSM_OFS_RESU2) |=> reg_rdata == $past(q_q.res2[11:4]))
      else $error("channel 2 upper result byte wrong");

   low_share_a: assert property (  // [RQ11]
      reg_rd && (reg_addr == `TSM_OFS_RESL) |=> reg_rdata == {$past(q_q.res2[3:0]), $past(q_q.res1[3:0])})
      else $error("shared lower result byte wrong");

   limit_low_a: assert property (  // [RQ13]
      reg_wr && (reg_addr == `TSM_OFS_LIML1) |=> q_q.lim_l1 == $past(reg_wdata[7:4]))
      else $error("lower limit nibble not taken from bits 7:4");

   peak_pub_a: assert property (  // [RQ15]
      c1_done |=> q_q.peak1 == $past(c1_peak))
      else $error("channel 1 peak not published");

   result_load_a: assert property (  // [RQ17]
      c1_done |=> q_q.res1 == $past(c1_res))
      else $error("channel 1 result not taken at period end");

   rdata_hold_a: assert property (  // [RQ10]
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   cfg_spare_a: assert property (  // [RQ2]
      q_q.cfg[7:6] == 2'b00)
      else $error("unused configuration bits not zero");

   low_sticky_a: assert property (  // [RQ9]
      c2_done && c2_lo |=> q_q.flags[`TSM_FL_LO2])
      else $error("channel 2 low flag not set");

   alert_release_a: assert property (  // [RQ12]
      flags_rd && !c1_done && !c2_done |=> alert_n)
      else $error("alert still low after status read");

   peak_two_a: assert property (  // [RQ16]
      c2_done |=> q_q.peak2 == $past(c2_peak))
      else $error("channel 2 peak not published");

   cover_high: cover property (c1_done && c1_hi);
   cover_turn: cover property (c2_done && c2_turn);
   cover_alert: cover property ($fell(alert_n));
   cover_clear: cover property (!alert_n ##1 flags_rd ##1 alert_n);
   cover_low: cover property (c2_done && c2_lo);
endmodule
`default_nettype wire

// >>> bench/tsm_temp_src.sv
// sample source model standing in for one channel's conversion logic
// assumes the monitor's clock; the testbench commands each strobe
`timescale 1ns/1ps
`default_nettype none

module tsm_temp_src
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               req,
   input  wire tsm_pkg::tsm_temp_t req_temp,
   output logic                    temp_valid,
   output tsm_pkg::tsm_temp_t      temp
);
   import tsm_pkg::*;

   // no sample outside a strobe: the bus toggles so stale data never looks held
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         temp_valid <= 1'b0;
         temp       <= 11'h000;
      end
      else
      begin
         temp_valid <= req;
         temp       <= req ? req_temp : ~temp;
      end
   end
endmodule

`default_nettype wire

// >>> bench/tsm_slope_monitor_tb.sv
// self-checking testbench of the slope monitor: register tasks and scenarios
// assumes the design package and the sample source model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tsm_slope_monitor_tb;
   import tsm_pkg::*;

   localparam tsm_temp_t HY_TBL [8] = '{11'h000, 11'h001, 11'h002, 11'h004,
                                        11'h008, 11'h010, 11'h018, 11'h020};
   logic        sys_clk;
   logic        rst_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, alert_n;
   logic        c1v, c2v, rq1, rq2;
   tsm_temp_t   c1t, c2t, rt1, rt2, t1, t2;
   logic [11:0] r1, r2;
   int          fails = 0;
   int          checked = 0;
   int          k, n;

   tsm_slope_monitor dut
   (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .ch1_temp_valid (c1v),
      .ch1_temp       (c1t),
      .ch2_temp_valid (c2v),
      .ch2_temp       (c2t),
      .alert_n        (alert_n)
   );
   tsm_temp_src u_src1 (.sys_clk(sys_clk), .rst_n(rst_n), .req(rq1), .req_temp(rt1), .temp_valid(c1v), .temp(c1t));
   tsm_temp_src u_src2 (.sys_clk(sys_clk), .rst_n(rst_n), .req(rq2), .req_temp(rt2), .temp_valid(c2v), .temp(c2t));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic finish_test();
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // data is registered, so it is taken one edge after the strobe is seen
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(posedge sys_clk);
      #1;
      d = reg_rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      logic [7:0] d;
      rd(a, d);
      chk(d & m, exp);
   endtask

   task automatic cfg(input logic [7:0] v);
      wr(8'h3E, 8'h00);
      wr(8'h3E, v);
   endtask

   task automatic smp(input logic [1:0] w, input tsm_temp_t a, input tsm_temp_t b);
      @(posedge sys_clk);
      rq1 <= w[0];
      rq2 <= w[1];
      rt1 <= a;
      rt2 <= b;
      @(posedge sys_clk);
      rq1 <= 1'b0;
      rq2 <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [7:0] rw_mask(input logic [7:0] a);
      case (a)
         8'h3D, 8'h41, 8'h46: return 8'hFF;
         8'h3E:               return 8'h3F;
         8'h42, 8'h47:        return 8'hF0;
         8'h43, 8'h48:        return 8'h0F;
         default:             return 8'h00;
      endcase
   endfunction

   // up, down and back: one reversal; the longer run adds a second one
   task automatic rev(input logic [2:0] h, input tsm_temp_t d, input logic ext, input logic [7:0] exp);
      tsm_temp_t pk;
      pk = ext ? 11'h200 + d + d + d : 11'h200 + d;
      cfg({5'b00100, h});
      wr(8'h43, {7'h00, ext} + 8'h01);
      wr(8'h48, {7'h00, ext} + 8'h01);
      smp(2'b11, 11'h200, 11'h200);
      smp(2'b11, 11'h200 + d, 11'h200 + d);
      smp(2'b11, 11'h200, 11'h200);
      if (ext)
      begin
         smp(2'b11, 11'h200 + d + d, 11'h200 + d + d);
         smp(2'b11, pk, pk);
      end
      rchk(8'h3F, exp, 8'hF0);
      rchk(8'h49, pk[10:3], 8'hFF);
      rchk(8'h4B, pk[10:3], 8'hFF);
      rchk(8'h4A, {pk[2:0], 5'h00}, 8'hFF);
      rchk(8'h4C, {pk[2:0], 5'h00}, 8'hFF);
   endtask

   // limit is 5 eighths: a step of 5 sits on it, a step of 6 crosses it
   task automatic ev(input logic c2, input logic up, input logic mk, input tsm_temp_t d);
      logic       hit;
      logic [7:0] fl;
      logic [7:0] junk;
      tsm_temp_t  t;
      hit = d > 11'h005;
      fl  = up ? (c2 ? 8'h08 : 8'h04) : (c2 ? 8'h02 : 8'h01);
      t   = up ? 11'h300 + d : 11'h300 - d;
      cfg(mk ? (c2 ? 8'h30 : 8'h28) : 8'h20);
      rd(8'h3F, junk);
      smp({c2, ~c2}, 11'h300, 11'h300);
      smp({c2, ~c2}, t, t);
      chk({7'h00, alert_n}, {7'h00, ~(hit & ~mk)});
      rchk(8'h3F, hit ? fl : 8'h00, 8'h0F);
      chk({7'h00, alert_n}, 8'h01);
      rchk(8'h3F, 8'h00, 8'h0F);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // about 6k cycles of traffic; the limit leaves ample margin
   initial
   begin
      #600000;
      fails++;
      finish_test();
   end

   initial
   begin
      rst_n     = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      rq1       = 1'b0;
      rq2       = 1'b0;
      rt1       = 11'h000;
      rt2       = 11'h000;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int a = 'h3C; a <= 'h50; a++)
         rchk(8'(a), 8'h00, 8'hFF);
      smp(2'b11, 11'h100, 11'h100);
      smp(2'b11, 11'h180, 11'h080);
      rchk(8'h40, 8'h00, 8'hFF);
      rchk(8'h44, 8'h00, 8'hFF);
      chk({7'h00, alert_n}, 8'h01);
      for (int a = 'h3C; a <= 'h50; a++)
      begin
         wr(8'(a), 8'hFF);
         rchk(8'(a), rw_mask(8'(a)), 8'hFF);
      end
      wr(8'h43, 8'h00);
      wr(8'h48, 8'h00);
      cfg(8'h20);
      t1 = 11'h100;
      t2 = 11'h100;
      smp(2'b11, t1, t2);
      for (int g = 0; g < 8; g++)
      begin
         wr(8'h3D, {2'b00, 3'(g), 3'(g)});
         t1 = t1 + 11'h001;
         t2 = t2 - 11'h001;
         smp(2'b11, t1, t2);
         r1 = 12'h001 << g;
         r2 = 12'h000 - r1;
         rchk(8'h40, r1[11:4], 8'hFF);
         rchk(8'h44, r2[11:4], 8'hFF);
         rchk(8'h45, {r2[3:0], r1[3:0]}, 8'hFF);
      end
      // stale results show a period that runs long; direction alternates
      wr(8'h3D, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         k = (i == 9) ? 15 : i;
         n = 1 << ((k > 8) ? 8 : k);
         wr(8'h43, 8'(k));
         for (int j = 0; j < n; j++)
         begin
            t1 = i[0] ? t1 - 11'h001 : t1 + 11'h001;
            smp(2'b01, t1, t2);
         end
         r1 = i[0] ? 12'hFFF : 12'h001;
         rchk(8'h40, r1[11:4], 8'hFF);
         rchk(8'h45, {4'h0, r1[3:0]}, 8'hFF);
      end
      for (int h = 0; h < 8; h++)
      begin
         rev(3'(h), HY_TBL[h] + 11'h001, 1'b0, 8'hF0);
         rev(3'(h), HY_TBL[h], 1'b0, 8'h00);
      end
      rev(3'h0, 11'h001, 1'b1, 8'hC0);
      // a monotonic period right after one with reversals reads clean
      for (int j = 1; j < 5; j++)
         smp(2'b11, 11'h203 + 11'(j), 11'h203 + 11'(j));
      rchk(8'h3F, 8'h00, 8'hF0);
      wr(8'h41, 8'h00);
      wr(8'h42, 8'h50);
      wr(8'h46, 8'h00);
      wr(8'h47, 8'h50);
      wr(8'h43, 8'h00);
      wr(8'h48, 8'h00);
      for (int e = 0; e < 16; e++)
         ev(e[3], e[2], e[1], e[0] ? 11'h006 : 11'h005);
      finish_test();
   end
endmodule

`default_nettype wire
